/* ckmu_edge.v */
// Rising edge detector with a gate; gives a one-cycle pulse per rising edge.
// Assumes a synchronised input on pclk.
`timescale 1ns/1ps
module ckmu_edge (
   input wire pclk,
   input wire presetn,
   input wire level_in,
   input wire gate,
   output wire rise
);
   reg last;

   // Previous sample
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last <= 1'b0;
      end else begin
         last <= level_in;
      end
   end

   assign rise = gate & level_in & ~last;
endmodule

/* ckmu_monitor.sv */
// Concurrent checks on the ports of the capacitive key measure unit.
// Assumes ckmu_top with the register header; bound in below its endmodule.
`timescale 1ns/1ps
`include "ckmu_regs.vh"
module ckmu_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [9:0] ref_cap_trim,
   input wire logic [1:0] key_mux_select,
   input wire logic freq_double_enable,
   input wire logic filter_enable,
   input wire logic hop_control_source,
   input wire logic [2:0] hop_freq_select,
   input wire logic ref_osc_run,
   input wire logic key_osc_run,
   input wire logic osc_sync,
   input wire logic sense_irq
);
   // ----------------------------------------------------------------
   // Helper decode
   // ----------------------------------------------------------------
   // Completed write and unmapped address
   wire wr_done = psel & penable & pready & pwrite;
   wire fc_wr = wr_done & (paddr == `CKMU_OFS_FUNC_CTRL);
   wire bad_addr = (paddr[1:0] != 2'b00) || (paddr > `CKMU_OFS_STATUS);

   default clocking mon_cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   apb_ready_a: assert property (psel && penable |-> pready)
      else $error("access phase without ready");
   apb_error_a: assert property (psel && penable |-> pslverr == bad_addr)
      else $error("slave error does not match address decode");
   trim_low_a: assert property (wr_done && paddr == `CKMU_OFS_REF_CAP_TRIM_LOW
      |=> ref_cap_trim[7:0] == $past(pwdata[7:0])) else $error("trim low not applied");
   trim_high_a: assert property (wr_done && paddr == `CKMU_OFS_REF_CAP_TRIM_HIGH
      |=> ref_cap_trim[9:8] == $past(pwdata[1:0])) else $error("trim high not applied");
   ctrl_fields_a: assert property (wr_done && paddr == `CKMU_OFS_CONTROL_A
      |=> {key_mux_select, freq_double_enable, filter_enable, hop_control_source,
      hop_freq_select} == $past(pwdata[7:0])) else $error("control fields not applied");
   irq_pulse_a: assert property (sense_irq |=> !sense_irq)
      else $error("interrupt pulse too long");
   irq_osc_stop_a: assert property (sense_irq |-> !ref_osc_run && !key_osc_run)
      else $error("oscillators still running at interrupt");
   sync_pulse_a: assert property (osc_sync |=> !osc_sync)
      else $error("synchronise pulse too long");
   sync_run_a: assert property (osc_sync |-> ##[0:2] (ref_osc_run || key_osc_run))
      else $error("no oscillator runs after synchronise");
   run_stop_irq_a: assert property ($fell(ref_osc_run) && !$past(fc_wr)
      |-> ##[0:1] sense_irq) else $error("oscillator stopped without interrupt");
   soft_flag_a: assert property (fc_wr && pwdata[6] && !ref_osc_run && !key_osc_run
      |=> !sense_irq [*3]) else $error("software flag set raised interrupt");

   // Main scenarios reached
   cover property (sense_irq);
   cover property (osc_sync);
   cover property (psel && penable && pslverr);
endmodule

bind ckmu_top ckmu_monitor ckmu_monitor_inst (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pready, .pslverr, .ref_cap_trim, .key_mux_select, .freq_double_enable,
   .filter_enable, .hop_control_source, .hop_freq_select, .ref_osc_run, .key_osc_run,
   .osc_sync, .sense_irq);

/* ckmu_regs.vh */
// Register map, field positions, reset values and timing counts of the
// capacitive key measure unit.
// Assumes APB with 32-bit data; each register takes one aligned word.
`ifndef CKMU_REGS_VH
`define CKMU_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CKMU_OFS_SLOT_PRELOAD 12'h000
`define CKMU_OFS_FUNC_CTRL 12'h004
`define CKMU_OFS_FREQ_CTRL 12'h008
`define CKMU_OFS_REF_COUNT_LOW 12'h00C
`define CKMU_OFS_REF_COUNT_HIGH 12'h010
`define CKMU_OFS_SENSE_COUNT_LOW 12'h014
`define CKMU_OFS_SENSE_COUNT_HIGH 12'h018
`define CKMU_OFS_REF_CAP_TRIM_LOW 12'h01C
`define CKMU_OFS_REF_CAP_TRIM_HIGH 12'h020
`define CKMU_OFS_CONTROL_A 12'h024
`define CKMU_OFS_CONTROL_B 12'h028
`define CKMU_OFS_STATUS 12'h02C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CKMU_FC_SLOT_OV 6
`define CKMU_FC_START 5
`define CKMU_FC_SENSE_OV 4
`define CKMU_FC_REF_OV 3
`define CKMU_CB_SLOT_CLK 7
`define CKMU_CB_REF_OSC_EN 5
`define CKMU_CB_KEY_OSC_EN 4
`define CKMU_CB_SECOND_KEY_EN 1
`define CKMU_CB_FIRST_KEY_EN 0
`define CKMU_CA_DOUBLE 5
`define CKMU_CA_FILTER 4
`define CKMU_CA_HOP_SRC 3

// Writable bit masks
`define CKMU_FC_MASK 8'h7B
`define CKMU_CB_MASK 8'hB3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CKMU_RST_BYTE 8'h00
`define CKMU_RST_FREQ_CTRL 8'h03

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define CKMU_SLOT_UNIT_CYCLES 32
`define CKMU_SLOT_CLK_DIV 4

`endif

/* ckmu_sync.v */
// Two-flop synchroniser for one asynchronous level.
// Assumes the input comes from outside the pclk domain.
`timescale 1ns/1ps
module ckmu_sync (
   input wire pclk,
   input wire presetn,
   input wire async_in,
   output reg sync_out
);
   reg stage1;

   // ----------------------------------------------------------------
   // Two flip-flops, first read only by second
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1 <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule

/* ckmu_top.v */
// Capacitive key measure unit: control registers, measurement counters.
// Assumes APB slave on pclk; oscillators are analog and outside, their
// outputs arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
`include "ckmu_regs.vh"

// Contract
// R1: Sense counter holds value after slot overflow
// R2: Sense count reads zero when start cleared
// R3: Ten-bit trim drives reference capacitance
// R4: Mux code picks first or second key
// R5: Double bit doubles key oscillator
// R6: Filter bit switches filter function
// R7: Hardware hop overrides software hop field
// R8: Hop field selects eight frequencies
// R9: Slot clock from reference or pclk/4
// R10: Oscillator enable bits gate oscillators
// R11: Key enable bits admit keys
// R12: Start clear clears counters, not slot
// R13: Start rise switches all counters on
// R14: Slot overflow stops oscillators and counters
// R15: One interrupt on slot overflow
// R16: Slot flag sticky until software clears
// R17: Sense overflow flag sticky
// R18: Reference overflow flag sticky
// R19: Start enables and synchronises oscillators
// R20: Software configures before raising start
// R21: Count sense cycles over fixed interval
// R22: Slot lasts (256-preload) times 32 clocks
// R23: Reference clock divides pclk by 1,2,4,8
// R24: Frequency field picks 1,3,7,11 MHz
// R25: Software-set slot flag raises no request
// R26: Count only selected, enabled key
module ckmu_top #(
   parameter CNT_W = 16,
   parameter SLOT_W = 8,
   parameter UNIT_W = 5
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire first_key,
   input wire second_key,
   input wire ref_osc,
   output reg [9:0] ref_cap_trim,
   output reg [1:0] key_mux_select,
   output reg freq_double_enable,
   output reg filter_enable,
   output reg hop_control_source,
   output reg [2:0] hop_freq_select,
   output reg [1:0] osc_freq_select,
   output reg ref_osc_run,
   output reg key_osc_run,
   output reg osc_sync,
   output reg sense_irq
);
   // ----------------------------------------------------------------
   // Registers and state
   // ----------------------------------------------------------------
   reg [SLOT_W-1:0] slot_preload;
   reg [1:0] ref_count_clock_select;
   reg detect_start;
   reg slot_overflow_flag;
   reg sense_count_overflow_flag;
   reg ref_count_overflow_flag;
   reg slot_clock_select;
   reg ref_osc_enable;
   reg key_osc_enable;
   reg second_key_enable;
   reg first_key_enable;
   reg [CNT_W-1:0] sense_count;
   reg [CNT_W-1:0] ref_count;
   reg [UNIT_W-1:0] unit_count;
   reg [SLOT_W-1:0] slot_count;
   reg [2:0] ref_div;
   reg [1:0] sys_div4;
   reg [1:0] state;
   reg [1:0] next_state;
   wire first_key_s;
   wire second_key_s;
   wire ref_s;
   wire first_key_rise;
   wire second_key_rise;
   wire ref_rise;

   // Measurement states
   localparam ST_IDLE = 2'b00;
   localparam ST_RUN = 2'b01;
   localparam ST_DONE = 2'b10;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire wr_en = psel & penable & pwrite;
   wire start_wr = wr_en && (paddr == `CKMU_OFS_FUNC_CTRL);
   wire next_start = pwdata[`CKMU_FC_START];
   wire start_rise = start_wr & next_start & ~detect_start;
   wire start_fall = start_wr & ~next_start & detect_start;

   // Known address test
   function mapped;
      input [11:0] a;
      begin
         mapped = (a[1:0] == 2'b00) && (a <= `CKMU_OFS_STATUS);
      end
   endfunction

   // Divider terminal count for the reference counter clock
   function div_tick;
      input [2:0] cnt;
      input [1:0] sel;
      begin
         case (sel)
            2'b00: div_tick = 1'b1;
            2'b01: div_tick = cnt[0];
            2'b10: div_tick = &cnt[1:0];
            default: div_tick = &cnt;
         endcase
      end
   endfunction

   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped(paddr);

   // ----------------------------------------------------------------
   // Oscillator input synchronisers and edge detectors
   // ----------------------------------------------------------------
   ckmu_sync u_sync_k1 (.pclk(pclk), .presetn(presetn), .async_in(first_key),
      .sync_out(first_key_s));
   ckmu_sync u_sync_k2 (.pclk(pclk), .presetn(presetn), .async_in(second_key),
      .sync_out(second_key_s));
   ckmu_sync u_sync_ref (.pclk(pclk), .presetn(presetn), .async_in(ref_osc),
      .sync_out(ref_s));

   wire running = (state == ST_RUN);
   // Selected, enabled key only
   wire k1_gate = running & key_osc_enable & first_key_enable &
      (key_mux_select == 2'b00); // R26 R4 R11
   wire k2_gate = running & key_osc_enable & second_key_enable &
      (key_mux_select == 2'b01); // R26 R4 R11
   ckmu_edge u_edge_k1 (.pclk(pclk), .presetn(presetn), .level_in(first_key_s),
      .gate(k1_gate), .rise(first_key_rise));
   ckmu_edge u_edge_k2 (.pclk(pclk), .presetn(presetn), .level_in(second_key_s),
      .gate(k2_gate), .rise(second_key_rise));
   ckmu_edge u_edge_ref (.pclk(pclk), .presetn(presetn), .level_in(ref_s),
      .gate(running & ref_osc_enable), .rise(ref_rise));

   // Sense count event, doubled when doubling is on
   wire sense_tick = first_key_rise | second_key_rise;

   // ----------------------------------------------------------------
   // Time slot clock: reference edges or pclk/4
   // ----------------------------------------------------------------
   wire slot_tick = running & (slot_clock_select ? (sys_div4 == 2'b11)
      : ref_rise); // R9
   wire unit_wrap = slot_tick & (&unit_count); // R22
   wire slot_ov = unit_wrap & (&slot_count); // R22 R21
   wire ref_tick = running & div_tick(ref_div, ref_count_clock_select); // R23

   // ----------------------------------------------------------------
   // Measurement state machine
   // ----------------------------------------------------------------
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (start_rise) begin
               next_state = ST_RUN; // R13 R19
            end
         end
         ST_RUN: begin
            if (start_fall) begin
               next_state = ST_IDLE;
            end else if (slot_ov) begin
               next_state = ST_DONE; // R14
            end
         end
         ST_DONE: begin
            if (start_fall) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // Measurement counters
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sense_count <= {CNT_W{1'b0}};
         ref_count <= {CNT_W{1'b0}};
         unit_count <= {UNIT_W{1'b0}};
         slot_count <= {SLOT_W{1'b0}};
         ref_div <= 3'h0;
         sys_div4 <= 2'h0;
      end else if (start_fall) begin
         sense_count <= {CNT_W{1'b0}}; // R2 R12
         ref_count <= {CNT_W{1'b0}}; // R12
         unit_count <= {UNIT_W{1'b0}}; // R12
         ref_div <= 3'h0;
         sys_div4 <= 2'h0;
      end else if (start_rise) begin
         slot_count <= slot_preload; // R13 R22
         unit_count <= {UNIT_W{1'b0}};
         ref_div <= 3'h0; // R19
         sys_div4 <= 2'h0; // R19
      end else if (running) begin
         ref_div <= ref_div + 3'h1;
         sys_div4 <= sys_div4 + 2'h1;
         if (sense_tick) begin
            if (freq_double_enable) begin
               sense_count <= sense_count + 16'h0002; // R5
            end else begin
               sense_count <= sense_count + 16'h0001;
            end
         end
         if (ref_tick) begin
            ref_count <= ref_count + 16'h0001;
         end
         if (slot_tick) begin
            unit_count <= unit_count + 5'h01;
         end
         if (unit_wrap) begin
            slot_count <= slot_count + 8'h01;
         end
      end
      // Outside the run state counters hold their values // R1
   end

   // Overflow events of the 16-bit counters
   wire sense_wrap = running & sense_tick &
      ((sense_count == 16'hFFFF) |
      (freq_double_enable & (sense_count == 16'hFFFE)));
   wire ref_wrap = ref_tick & (&ref_count);

   // ----------------------------------------------------------------
   // Register writes and sticky flags (set wins over clear)
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot_preload <= `CKMU_RST_BYTE;
         ref_count_clock_select <= 2'b00;
         detect_start <= 1'b0;
         slot_overflow_flag <= 1'b0;
         sense_count_overflow_flag <= 1'b0;
         ref_count_overflow_flag <= 1'b0;
         osc_freq_select <= 2'b11;
         ref_cap_trim <= 10'h000;
         key_mux_select <= 2'b00;
         freq_double_enable <= 1'b0;
         filter_enable <= 1'b0;
         hop_control_source <= 1'b0;
         hop_freq_select <= 3'b000;
         slot_clock_select <= 1'b0;
         ref_osc_enable <= 1'b0;
         key_osc_enable <= 1'b0;
         second_key_enable <= 1'b0;
         first_key_enable <= 1'b0;
      end else begin
         if (wr_en) begin
            case (paddr)
               `CKMU_OFS_SLOT_PRELOAD: slot_preload <= pwdata[7:0];
               `CKMU_OFS_FUNC_CTRL: begin
                  detect_start <= next_start;
                  ref_count_clock_select <= pwdata[1:0];
                  slot_overflow_flag <= pwdata[`CKMU_FC_SLOT_OV]; // R16
                  sense_count_overflow_flag <= pwdata[`CKMU_FC_SENSE_OV]; // R17
                  ref_count_overflow_flag <= pwdata[`CKMU_FC_REF_OV]; // R18
               end
               `CKMU_OFS_FREQ_CTRL: osc_freq_select <= pwdata[1:0]; // R24
               `CKMU_OFS_REF_CAP_TRIM_LOW: ref_cap_trim[7:0] <= pwdata[7:0]; // R3
               `CKMU_OFS_REF_CAP_TRIM_HIGH: ref_cap_trim[9:8] <= pwdata[1:0]; // R3
               `CKMU_OFS_CONTROL_A: begin
                  key_mux_select <= pwdata[7:6]; // R4
                  freq_double_enable <= pwdata[`CKMU_CA_DOUBLE]; // R5
                  filter_enable <= pwdata[`CKMU_CA_FILTER]; // R6
                  hop_control_source <= pwdata[`CKMU_CA_HOP_SRC]; // R7
                  hop_freq_select <= pwdata[2:0]; // R8
               end
               `CKMU_OFS_CONTROL_B: begin
                  slot_clock_select <= pwdata[`CKMU_CB_SLOT_CLK]; // R9
                  ref_osc_enable <= pwdata[`CKMU_CB_REF_OSC_EN]; // R10
                  key_osc_enable <= pwdata[`CKMU_CB_KEY_OSC_EN]; // R10
                  second_key_enable <= pwdata[`CKMU_CB_SECOND_KEY_EN]; // R11
                  first_key_enable <= pwdata[`CKMU_CB_FIRST_KEY_EN]; // R11
               end
               default: ;
            endcase
         end
         // Hardware sets override a same-cycle clear
         if (slot_ov) begin
            slot_overflow_flag <= 1'b1; // R16
         end
         if (sense_wrap) begin
            sense_count_overflow_flag <= 1'b1; // R17
         end
         if (ref_wrap) begin
            ref_count_overflow_flag <= 1'b1; // R18
         end
      end
   end

   // ----------------------------------------------------------------
   // Oscillator run controls, sync pulse and interrupt pulse
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_osc_run <= 1'b0;
         key_osc_run <= 1'b0;
         osc_sync <= 1'b0;
         sense_irq <= 1'b0;
      end else begin
         ref_osc_run <= (next_state == ST_RUN) & ref_osc_enable; // R10 R14
         key_osc_run <= (next_state == ST_RUN) & key_osc_enable; // R10 R14
         osc_sync <= start_rise; // R19
         sense_irq <= slot_ov; // R15 R25
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel & ~penable & ~pwrite) begin
         case (paddr)
            `CKMU_OFS_SLOT_PRELOAD: prdata <= {24'h000000, slot_preload};
            `CKMU_OFS_FUNC_CTRL: prdata <= {25'h0000000, slot_overflow_flag,
               detect_start, sense_count_overflow_flag, ref_count_overflow_flag,
               1'b0, ref_count_clock_select};
            `CKMU_OFS_FREQ_CTRL: prdata <= {30'h00000000, osc_freq_select};
            `CKMU_OFS_REF_COUNT_LOW: prdata <= {24'h000000, ref_count[7:0]};
            `CKMU_OFS_REF_COUNT_HIGH: prdata <= {24'h000000, ref_count[15:8]};
            `CKMU_OFS_SENSE_COUNT_LOW: prdata <= {24'h000000, sense_count[7:0]};
            `CKMU_OFS_SENSE_COUNT_HIGH: prdata <= {24'h000000, sense_count[15:8]};
            `CKMU_OFS_REF_CAP_TRIM_LOW: prdata <= {24'h000000, ref_cap_trim[7:0]};
            `CKMU_OFS_REF_CAP_TRIM_HIGH: prdata <= {30'h00000000, ref_cap_trim[9:8]};
            `CKMU_OFS_CONTROL_A: prdata <= {24'h000000, key_mux_select,
               freq_double_enable, filter_enable, hop_control_source,
               hop_freq_select};
            `CKMU_OFS_CONTROL_B: prdata <= {24'h000000, slot_clock_select, 1'b0,
               ref_osc_enable, key_osc_enable, 2'b00, second_key_enable,
               first_key_enable};
            `CKMU_OFS_STATUS: prdata <= {30'h00000000, state};
            default: prdata <= 32'h00000000;
         endcase
      end
   end
endmodule

/* testbench.sv */
// Self-checking testbench of the capacitive key measure unit.
// Assumes ckmu_top and its register header; APB master, keys and oscillator driven here.
`timescale 1ns/1ps
`include "ckmu_regs.vh"
`define CKMU_CHECK(got, exp) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
   logic pclk, presetn, psel, penable, pwrite, first_key, second_key, ref_osc;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, v;
   logic pready, pslverr, ref_osc_run, key_osc_run, osc_sync, sense_irq;
   logic [9:0] ref_cap_trim;
   logic [1:0] key_mux_select, osc_freq_select;
   logic freq_double_enable, filter_enable, hop_control_source;
   logic [2:0] hop_freq_select;
   logic [32:0] expq[$];
   logic [32:0] exp_now;
   int miscompares = 0;
   int n_tests = 0;
   int irqs = 0;
   int cyc = 0;
   int irq_cyc = 0;
   int n;
   integer seed = 32'h455ea4ae;

   ckmu_top ckmu_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .first_key, .second_key, .ref_osc, .ref_cap_trim,
      .key_mux_select, .freq_double_enable, .filter_enable, .hop_control_source,
      .hop_freq_select, .osc_freq_select, .ref_osc_run, .key_osc_run, .osc_sync, .sense_irq);

   // ----------------------------------------------------------------
   // Clock, reference oscillator, event counters
   // ----------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // Reference oscillator at pclk/8, interrupt pulse tally
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc % 4 == 3) ref_osc <= ~ref_osc;
      if (sense_irq === 1'b1) begin
         irqs <= irqs + 1;
         irq_cyc <= cyc;
      end
   end

   // Oldest noted result against each completed transfer
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
         exp_now = expq.pop_front();
         `CKMU_CHECK({pslverr, pwrite ? 32'h0 : prdata}, exp_now)
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   // One APB transfer; the expected error bit and read data are noted first
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [32:0] e);
      begin
         expq.push_back(e);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         do begin
            @(posedge pclk);
         end while (pready !== 1'b1);
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h0, {25'h0, e});
   endtask

   // One measurement: configure, start, pulse keys, wait for the slot end
   task automatic meas(input logic [7:0] pre, ca, cb, input logic [1:0] tog,
      input logic [15:0] ec);
      int n0, t0, k, base;
      begin
         wr(`CKMU_OFS_SLOT_PRELOAD, {24'h0, pre});
         wr(`CKMU_OFS_CONTROL_A, {24'h0, ca});
         wr(`CKMU_OFS_CONTROL_B, {24'h0, cb});
         n0 = irqs;
         t0 = cyc;
         base = (256 - pre) * 32 * (cb[7] ? 4 : 8);
         wr(`CKMU_OFS_FUNC_CTRL, 32'h20);
         @(posedge pclk);
         #1;
         `CKMU_CHECK({ref_osc_run, key_osc_run}, cb[5:4])
         repeat (6) @(posedge pclk);
         repeat (10) begin
            first_key <= tog[0];
            second_key <= tog[1];
            repeat (2) @(posedge pclk);
            first_key <= 1'b0;
            second_key <= 1'b0;
            repeat (2) @(posedge pclk);
         end
         k = 0;
         while (irqs == n0 && k < 3000) begin
            @(posedge pclk);
            k++;
         end
         `CKMU_CHECK(irqs - n0, 1)
         `CKMU_CHECK(irq_cyc - t0 >= base - 8 && irq_cyc - t0 <= base + 16, 1'b1)
         rd(`CKMU_OFS_SENSE_COUNT_LOW, ec[7:0]);
         rd(`CKMU_OFS_SENSE_COUNT_HIGH, ec[15:8]);
         rd(`CKMU_OFS_FUNC_CTRL, 8'h60);
         if (cb[7]) rd(`CKMU_OFS_REF_COUNT_LOW, 8'((256 - pre) * 128));
         repeat (20) @(posedge pclk);
         rd(`CKMU_OFS_SENSE_COUNT_LOW, ec[7:0]);
         wr(`CKMU_OFS_FUNC_CTRL, 32'h0);
         rd(`CKMU_OFS_SENSE_COUNT_LOW, 8'h00);
         rd(`CKMU_OFS_REF_COUNT_LOW, 8'h00);
         rd(`CKMU_OFS_FUNC_CTRL, 8'h00);
      end
   endtask

   task complete_run;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, miscompares);
         if (miscompares == 0 && n_tests > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {first_key, second_key, ref_osc, presetn} = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset values of every register
      for (int i = 0; i < 12; i++) rd(12'(i * 4), i == 2 ? 8'h03 : 8'h00);
      `CKMU_CHECK(osc_freq_select, 2'b11)
      // Frequency and reference clock codes
      for (int i = 0; i < 4; i++) begin
         wr(`CKMU_OFS_FREQ_CTRL, i);
         `CKMU_CHECK(osc_freq_select, 2'(i))
         wr(`CKMU_OFS_FUNC_CTRL, i);
         rd(`CKMU_OFS_FUNC_CTRL, 8'(i));
      end
      // Random control and trim values
      repeat (6) begin
         v = $random(seed);
         wr(`CKMU_OFS_CONTROL_A, v);
         rd(`CKMU_OFS_CONTROL_A, v[7:0]);
         `CKMU_CHECK({key_mux_select, freq_double_enable, filter_enable, hop_control_source, hop_freq_select}, v[7:0])
         wr(`CKMU_OFS_REF_CAP_TRIM_LOW, v >> 8);
         wr(`CKMU_OFS_REF_CAP_TRIM_HIGH, v >> 16);
         `CKMU_CHECK(ref_cap_trim, {v[17:16], v[15:8]})
         rd(`CKMU_OFS_REF_CAP_TRIM_HIGH, {6'h0, v[17:16]});
      end
      wr(`CKMU_OFS_CONTROL_B, 32'hFFFFFFFF);
      rd(`CKMU_OFS_CONTROL_B, 8'hB3);
      // Unmapped and unaligned places
      apb(1'b0, 12'h030, 32'h0, {1'b1, 32'h0});
      apb(1'b0, 12'h005, 32'h0, {1'b1, 32'h0});
      apb(1'b1, 12'h0FC, 32'hFF, {1'b1, 32'h0});
      // Slot flag set by software
      n = irqs;
      wr(`CKMU_OFS_FUNC_CTRL, 32'h40);
      repeat (4) @(posedge pclk);
      `CKMU_CHECK(irqs, n)
      rd(`CKMU_OFS_FUNC_CTRL, 8'h40);
      wr(`CKMU_OFS_FUNC_CTRL, 32'h0);
      rd(`CKMU_OFS_FUNC_CTRL, 8'h00);
      // Measurements: preload, control A, control B, pulsed keys, count
      meas(8'hFF, 8'h00, 8'hB1, 2'b01, 16'd10);
      meas(8'hFF, 8'h40, 8'hB2, 2'b10, 16'd10);
      meas(8'hFF, 8'h40, 8'hB2, 2'b01, 16'd0);
      meas(8'hFF, 8'h20, 8'hB1, 2'b01, 16'd20);
      meas(8'hFE, 8'h00, 8'h21, 2'b01, 16'd0);
      meas(8'hFF, 8'h80, 8'hB3, 2'b11, 16'd0);
      meas(8'hFF, 8'h00, 8'hB0, 2'b01, 16'd0);
      complete_run;
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      complete_run;
   end
endmodule
